// [verilog/cxm_exec.sv]
// execution unit for code constant loads, external data moves, multiply, idle and OR operations
`timescale 1ns/1ps
`default_nettype none
`include "cxm_consts.svh"
module cxm_exec #(
	parameter int unsigned MC_CLKS = `CXM_MC_CLKS
) (
	// clock and reset
	input  wire logic          CLK_SYS_I,
	input  wire logic          RESETN_I,
	// apb slave
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [7:0]    PADDR_I,
	input  wire logic [31:0]   PWDATA_I,
	output logic [31:0]        PRDATA_O,
	output logic               PREADY_O,
	output logic               PSLVERR_O,
	// program memory fetch
	output logic [15:0]        CODE_ADDR_O,
	output logic               CODE_REQ_O,
	input  wire logic [7:0]    CODE_DATA_I,
	input  wire logic          CODE_ACK_I,
	// external data bus and ports
	output cxm_pkg::cxm_xbus_t XBUS_O,
	input  wire logic [7:0]    P0_PIN_I,
	input  wire logic [7:0]    P1_PIN_I,
	output logic [7:0]         P1_O
);
	import cxm_pkg::*;

	localparam int unsigned    CW      = $clog2(4 * MC_CLKS + 1);
	localparam logic [CW-1:0]  MC_C    = CW'(MC_CLKS);
	localparam logic [CW-1:0]  HALF_C  = CW'(MC_CLKS / 2);
	localparam logic [CW-1:0]  STB_END = CW'(2 * MC_CLKS - 1);
	localparam logic [CW-1:0]  SMP_C   = CW'(2 * MC_CLKS - 2);

	cxm_state_t    st_q;
	cxm_cmd_t      cmd_q;
	cxm_cmd_t      new_cmd;
	cxm_xbus_t     xbus_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] last_q;
	logic [7:0]    acc_q, b_q, p1_q, p2_q;
	logic [7:0]    acc_d, b_d;
	logic [15:0]   dptr_q, pc_q, pc_adv;
	logic          cy_q, ov_q, cy_d, ov_d;
	logic [1:0]    bank_q;
	logic [7:0]    ram_q [0:31];
	logic          code_req_q, code_got_q;
	logic [7:0]    code_q, xd_q;
	logic [15:0]   code_addr_q, xa;
	logic [7:0]    p0_s1_q, p0_s2_q, p0_s3_q, p0_f_q;
	logic [7:0]    p1_s1_q, p1_s2_q, p1_s3_q, p1_f_q;
	logic [31:0]   prdata_q;
	logic [7:0]    ri_val, reg_val, ind_val, dw_v, bit_src;
	logic          dw_en, bitv, busy, cmd_go, reg_wr, apb_acc;
	logic [15:0]   prod;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic op_movx(input cxm_op_t op);
		return op inside {CXM_OP_MOVX_RD_RI, CXM_OP_MOVX_WR_RI, CXM_OP_MOVX_RD_DP, CXM_OP_MOVX_WR_DP};
	endfunction

	function automatic logic op_long(input cxm_op_t op);
		return op inside {CXM_OP_MOVX_RD_DP, CXM_OP_MOVX_WR_DP};
	endfunction

	function automatic logic op_wr(input cxm_op_t op);
		return op inside {CXM_OP_MOVX_WR_RI, CXM_OP_MOVX_WR_DP};
	endfunction

	function automatic logic op_movc(input cxm_op_t op);
		return op inside {CXM_OP_MOVC_DP, CXM_OP_MOVC_PC};
	endfunction

	// instruction length in code bytes
	function automatic logic [15:0] op_len(input cxm_op_t op);
		if (op == CXM_OP_ORL_DIR_IM) begin
			return 16'h0003;
		end
		if (op inside {CXM_OP_ORL_A_DIR, CXM_OP_ORL_A_IMM, CXM_OP_ORL_DIR_A,
				CXM_OP_ORL_C_BIT, CXM_OP_ORL_C_NBIT}) begin
			return 16'h0002;
		end
		return 16'h0001;
	endfunction

	// duration in clocks minus one, whole machine cycles
	function automatic logic [CW-1:0] op_clks(input cxm_op_t op);
		int unsigned mcs;
		mcs = 1;
		if (op == CXM_OP_MUL) begin
			mcs = 4;
		end else if (op_movx(op) || op_movc(op) || op inside {CXM_OP_ORL_DIR_IM,
				CXM_OP_ORL_C_BIT, CXM_OP_ORL_C_NBIT}) begin
			mcs = 2;
		end
		return CW'(mcs * MC_CLKS - 1);
	endfunction

	// direct byte read; port one comes from the latch only for read-modify-write, port two always from its latch
	function automatic logic [7:0] dir_rd(input logic [5:0] a, input logic latch);
		if (a < `CXM_DIR_P1) begin
			return ram_q[a[4:0]];
		end
		case (a)
			`CXM_DIR_P1:  return latch ? p1_q : p1_f_q;
			`CXM_DIR_P2:  return p2_q;
			`CXM_DIR_ACC: return acc_q;
			`CXM_DIR_B:   return b_q;
			default:      return 8'h00;
		endcase
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a[7] || a <= `CXM_OFS_PORTS);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, writes refused while an operation runs

	assign busy      = (st_q != CXM_ST_WAIT);
	assign apb_acc   = PSEL_I && PENABLE_I;
	assign new_cmd   = cxm_cmd_t'(PWDATA_I);
	assign cmd_go    = apb_acc && PWRITE_I && !busy && (PADDR_I == `CXM_OFS_CMD);
	assign reg_wr    = apb_acc && PWRITE_I && !busy && addr_ok(PADDR_I);
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = apb_acc && (!addr_ok(PADDR_I) || (PWRITE_I && busy));
	assign PRDATA_O  = prdata_q;

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			prdata_q <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I) begin
			prdata_q <= 32'h0000_0000;
			if (PADDR_I[7] && PADDR_I[1:0] == 2'b00) begin
				prdata_q <= {24'h00_0000, ram_q[PADDR_I[6:2]]};
			end else begin
				case (PADDR_I)
					`CXM_OFS_CMD:   prdata_q <= cmd_q;
					`CXM_OFS_STAT:  prdata_q <= {24'h00_0000, 2'b00, cmd_q.op, busy};
					`CXM_OFS_ACC:   prdata_q <= {24'h00_0000, acc_q};
					`CXM_OFS_B:     prdata_q <= {24'h00_0000, b_q};
					`CXM_OFS_DPTR:  prdata_q <= {16'h0000, dptr_q};
					`CXM_OFS_PC:    prdata_q <= {16'h0000, pc_q};
					`CXM_OFS_PSW:   prdata_q <= {27'h000_0000, bank_q, 1'b0, ov_q, cy_q};
					`CXM_OFS_PORTS: prdata_q <= {16'h0000, p2_q, p1_q};
					default:        prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer: wait, run for whole machine cycles, longer while a code byte is late, commit in one cycle

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_q   <= CXM_ST_WAIT;
			cmd_q  <= '0;
			cnt_q  <= '0;
			last_q <= '0;
		end else begin
			unique case (st_q)
				CXM_ST_WAIT: begin
					if (cmd_go) begin
						cmd_q  <= new_cmd;
						cnt_q  <= '0;
						last_q <= op_clks(new_cmd.op);
						st_q   <= CXM_ST_RUN;
					end
				end
				CXM_ST_RUN: begin
					// a late code byte stretches the last cycle
					if (cnt_q != last_q) begin
						cnt_q <= cnt_q + 1'b1;
					end else if (!op_movc(cmd_q.op) || code_got_q) begin
						st_q <= CXM_ST_DONE;
					end
				end
				CXM_ST_DONE: begin
					st_q <= CXM_ST_WAIT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// program counter and data pointer

	// base is advanced first so a table may follow the instruction
	assign pc_adv = pc_q + op_len(new_cmd.op);

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pc_q   <= `CXM_RST_WORD;
			dptr_q <= `CXM_RST_WORD;
		end else if (st_q == CXM_ST_WAIT && cmd_go) begin
			pc_q <= pc_adv;
		end else if (reg_wr && PADDR_I == `CXM_OFS_PC) begin
			pc_q <= PWDATA_I[15:0];
		end else if (reg_wr && PADDR_I == `CXM_OFS_DPTR) begin
			dptr_q <= PWDATA_I[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// code memory request, held until acknowledged

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			code_req_q  <= 1'b0;
			code_got_q  <= 1'b0;
			code_addr_q <= `CXM_RST_WORD;
			code_q      <= `CXM_RST_BYTE;
		end else if (st_q == CXM_ST_WAIT && cmd_go && op_movc(new_cmd.op)) begin
			code_req_q <= 1'b1;
			code_got_q <= 1'b0;
			// full sixteen-bit sum; the data pointer is only read
			if (new_cmd.op == CXM_OP_MOVC_PC) begin
				code_addr_q <= pc_adv + {8'h00, acc_q};
			end else begin
				code_addr_q <= dptr_q + {8'h00, acc_q};
			end
		end else if (code_req_q && CODE_ACK_I) begin
			code_req_q <= 1'b0;
			code_got_q <= 1'b1;
			code_q     <= CODE_DATA_I;
		end
	end

	assign CODE_REQ_O  = code_req_q;
	assign CODE_ADDR_O = code_addr_q;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once stages two and three agree

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			p0_s1_q <= 8'h00;
			p0_s2_q <= 8'h00;
			p0_s3_q <= 8'h00;
			p0_f_q  <= 8'h00;
			p1_s1_q <= 8'h00;
			p1_s2_q <= 8'h00;
			p1_s3_q <= 8'h00;
			p1_f_q  <= 8'h00;
		end else begin
			p0_s1_q <= P0_PIN_I;
			p0_s2_q <= p0_s1_q;
			p0_s3_q <= p0_s2_q;
			p1_s1_q <= P1_PIN_I;
			p1_s2_q <= p1_s1_q;
			p1_s3_q <= p1_s2_q;
			if (p0_s2_q == p0_s3_q) begin
				p0_f_q <= p0_s3_q;
			end
			if (p1_s2_q == p1_s3_q) begin
				p1_f_q <= p1_s3_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// external data bus: address phase in machine cycle one, strobe in two

	assign ri_val = ram_q[{bank_q, 2'b00, cmd_q.rsel[0]}];
	// short form puts only eight bits out; higher bits come from port pins set by software
	assign xa = op_long(cmd_q.op) ? dptr_q : {8'h00, ri_val};

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			xbus_q <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, p0_oe: 1'b0, p0: 8'h00, p2: `CXM_RST_PORT};
			xd_q   <= `CXM_RST_BYTE;
		end else begin
			xbus_q <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, p0_oe: 1'b0, p0: 8'h00, p2: p2_q};
			if (st_q == CXM_ST_RUN && op_movx(cmd_q.op)) begin
				xbus_q.ale   <= (cnt_q < HALF_C);
				xbus_q.p0_oe <= (cnt_q < MC_C) || op_wr(cmd_q.op);
				xbus_q.p0    <= (cnt_q < MC_C) ? xa[7:0] : acc_q;
				xbus_q.rd_n  <= !(!op_wr(cmd_q.op) && cnt_q >= MC_C && cnt_q < STB_END);
				xbus_q.wr_n  <= !(op_wr(cmd_q.op) && cnt_q >= MC_C && cnt_q < STB_END);
				// port_two pins show the pointer while the latch keeps its value
				xbus_q.p2    <= op_long(cmd_q.op) ? xa[15:8] : p2_q;
				if (!op_wr(cmd_q.op) && cnt_q == SMP_C) begin
					xd_q <= p0_f_q;
				end
			end
		end
	end

	assign XBUS_O = xbus_q;

	////////////////////////////////////////////////////////////////////////////
	// results, formed in the commit cycle from stable operands

	assign reg_val = ram_q[{bank_q, cmd_q.rsel}];
	assign ind_val = (ri_val < 8'h20) ? ram_q[ri_val[4:0]] : 8'h00;
	assign bitv    = bit_src[cmd_q.bitsel];
	assign prod    = {8'h00, acc_q} * {8'h00, b_q};

	// bit source byte in a process, so ram, latch and pin changes re-evaluate it
	always_comb begin
		bit_src = dir_rd(cmd_q.dir, 1'b0);
	end

	always_comb begin
		acc_d = acc_q;
		b_d   = b_q;
		cy_d  = cy_q;
		ov_d  = ov_q;
		dw_en = 1'b0;
		dw_v  = 8'h00;
		unique case (cmd_q.op)
			CXM_OP_IDLE: ;
			CXM_OP_MOVC_DP, CXM_OP_MOVC_PC: acc_d = code_q;
			CXM_OP_MOVX_RD_RI, CXM_OP_MOVX_RD_DP: acc_d = xd_q;
			CXM_OP_MOVX_WR_RI, CXM_OP_MOVX_WR_DP: ;
			CXM_OP_MUL: begin
				acc_d = prod[7:0];
				b_d   = prod[15:8];
				ov_d  = (prod[15:8] != 8'h00);
				cy_d  = 1'b0;
			end
			CXM_OP_ORL_A_REG: acc_d = acc_q | reg_val;
			CXM_OP_ORL_A_DIR: acc_d = acc_q | dir_rd(cmd_q.dir, 1'b0);
			CXM_OP_ORL_A_IND: acc_d = acc_q | ind_val;
			CXM_OP_ORL_A_IMM: acc_d = acc_q | cmd_q.imm;
			CXM_OP_ORL_DIR_A, CXM_OP_ORL_DIR_IM: begin
				dw_en = 1'b1;
				// a port destination is modified from its latch, not its pins
				dw_v  = dir_rd(cmd_q.dir, 1'b1) | ((cmd_q.op == CXM_OP_ORL_DIR_A) ? acc_q : cmd_q.imm);
			end
			CXM_OP_ORL_C_BIT: cy_d = cy_q | bitv;
			CXM_OP_ORL_C_NBIT: cy_d = cy_q | ~bitv;
			default: ;
		endcase
		if (dw_en && cmd_q.dir == `CXM_DIR_ACC) begin
			acc_d = dw_v;
		end
		if (dw_en && cmd_q.dir == `CXM_DIR_B) begin
			b_d = dw_v;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// accumulator and second operand, written together only at commit

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			acc_q <= `CXM_RST_BYTE;
			b_q   <= `CXM_RST_BYTE;
		end else if (st_q == CXM_ST_DONE) begin
			acc_q <= acc_d;
			b_q   <= b_d;
		end else if (reg_wr && PADDR_I == `CXM_OFS_ACC) begin
			acc_q <= PWDATA_I[7:0];
		end else if (reg_wr && PADDR_I == `CXM_OFS_B) begin
			b_q <= PWDATA_I[7:0];
		end
	end

	// flags and bank select
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cy_q   <= 1'b0;
			ov_q   <= 1'b0;
			bank_q <= 2'b00;
		end else if (st_q == CXM_ST_DONE) begin
			cy_q <= cy_d;
			ov_q <= ov_d;
		end else if (reg_wr && PADDR_I == `CXM_OFS_PSW) begin
			cy_q   <= PWDATA_I[`CXM_PSW_CY];
			ov_q   <= PWDATA_I[`CXM_PSW_OV];
			bank_q <= PWDATA_I[`CXM_PSW_BANK +: 2];
		end
	end

	// port output latches
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			p1_q <= `CXM_RST_PORT;
			p2_q <= `CXM_RST_PORT;
		end else if (st_q == CXM_ST_DONE && dw_en && cmd_q.dir == `CXM_DIR_P1) begin
			p1_q <= dw_v;
		end else if (st_q == CXM_ST_DONE && dw_en && cmd_q.dir == `CXM_DIR_P2) begin
			p2_q <= dw_v;
		end else if (reg_wr && PADDR_I == `CXM_OFS_PORTS) begin
			p1_q <= PWDATA_I[7:0];
			p2_q <= PWDATA_I[15:8];
		end
	end

	assign P1_O = p1_q;

	// internal ram holds data only, so it carries no reset
	always_ff @(posedge CLK_SYS_I) begin
		if (st_q == CXM_ST_DONE && dw_en && cmd_q.dir < `CXM_DIR_P1) begin
			ram_q[cmd_q.dir[4:0]] <= dw_v;
		end else if (reg_wr && PADDR_I[7]) begin
			ram_q[PADDR_I[6:2]] <= PWDATA_I[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);

	chk_movc_dptr_addr: assert property (cmd_go && new_cmd.op == CXM_OP_MOVC_DP |=>
		CODE_REQ_O && CODE_ADDR_O == $past(dptr_q) + {8'h00, $past(acc_q)})
		else $error("code fetch address from data pointer wrong");
	chk_movc_pc_base: assert property (cmd_go && new_cmd.op == CXM_OP_MOVC_PC |=>
		pc_q == $past(pc_q) + 16'h0001 && CODE_ADDR_O == pc_q + {8'h00, acc_q})
		else $error("program counter not advanced before code fetch sum");
	chk_movc_result: assert property (st_q == CXM_ST_DONE && op_movc(cmd_q.op) |=>
		acc_q == $past(code_q) && $stable(dptr_q) && $stable(cy_q) && $stable(ov_q))
		else $error("code constant load result or side effects wrong");
	chk_short_addr: assert property (st_q == CXM_ST_RUN && op_movx(cmd_q.op) && !op_long(cmd_q.op)
		&& cnt_q == 2 |-> XBUS_O.ale && XBUS_O.p0_oe && XBUS_O.p0 == ri_val && XBUS_O.p2 == p2_q)
		else $error("short external address not on port_zero");
	chk_long_addr: assert property (st_q == CXM_ST_RUN && op_long(cmd_q.op) && cnt_q == 2 |->
		XBUS_O.p2 == dptr_q[15:8] && XBUS_O.p0 == dptr_q[7:0])
		else $error("long external address not on ports");
	chk_p2_latch_kept: assert property (st_q == CXM_ST_RUN && op_long(cmd_q.op) |=> $stable(p2_q)
		##1 (st_q != CXM_ST_RUN) || XBUS_O.p2 == dptr_q[15:8] || cnt_q < 2)
		else $error("port_two latch disturbed by long move");
	chk_mul_result: assert property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_MUL |=>
		{b_q, acc_q} == {8'h00, $past(acc_q)} * {8'h00, $past(b_q)} && ov_q == (b_q != 8'h00) && !cy_q)
		else $error("multiply result or flags wrong");
	chk_mul_atomic: assert property (st_q == CXM_ST_RUN && cmd_q.op == CXM_OP_MUL |=>
		$stable(acc_q) && $stable(b_q))
		else $error("partial product visible during multiply");
	chk_idle_quiet: assert property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_IDLE |=>
		$stable(acc_q) && $stable(b_q) && $stable(cy_q) && $stable(ov_q) && $stable(dptr_q) && $stable(p1_q))
		else $error("idle instruction changed state");
	chk_orl_port_latch: assert property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_ORL_DIR_IM
		&& cmd_q.dir == `CXM_DIR_P1 |=> P1_O == ($past(p1_q) | $past(cmd_q.imm)) && $stable(cy_q))
		else $error("port OR not taken from latch");
	chk_orl_acc_imm: assert property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_ORL_A_IMM |=>
		acc_q == ($past(acc_q) | $past(cmd_q.imm)) && $stable(ov_q))
		else $error("accumulator OR immediate wrong");
	chk_orl_carry: assert property (st_q == CXM_ST_DONE && cmd_q.op inside {CXM_OP_ORL_C_BIT, CXM_OP_ORL_C_NBIT}
		|=> cy_q == ($past(cy_q) | ($past(bitv) ^ ($past(cmd_q.op) == CXM_OP_ORL_C_NBIT))) && $stable(ov_q))
		else $error("bit OR into carry wrong");
	chk_mc_length: assert property (cmd_go && new_cmd.op == CXM_OP_IDLE |->
		##12 (st_q == CXM_ST_RUN) ##1 (st_q == CXM_ST_DONE))
		else $error("idle instruction not one machine cycle");

	cov_movc_pc: cover property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_MOVC_PC);
	cov_movx_long_rd: cover property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_MOVX_RD_DP);
	cov_mul_over: cover property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_MUL ##1 ov_q);
	cov_orl_port: cover property (st_q == CXM_ST_DONE && cmd_q.op == CXM_OP_ORL_DIR_A && cmd_q.dir == `CXM_DIR_P1);

endmodule
`default_nettype wire

// [verilog/cxm_consts.svh]
// register offsets, field positions, reset values and timing counts of the execution unit
`ifndef CXM_CONSTS_SVH
`define CXM_CONSTS_SVH

// clock periods in one machine cycle
`define CXM_MC_CLKS 12

// apb byte offsets
`define CXM_OFS_CMD   8'h00
`define CXM_OFS_STAT  8'h04
`define CXM_OFS_ACC   8'h08
`define CXM_OFS_B     8'h0c
`define CXM_OFS_DPTR  8'h10
`define CXM_OFS_PC    8'h14
`define CXM_OFS_PSW   8'h18
`define CXM_OFS_PORTS 8'h1c
`define CXM_OFS_RAM   8'h80

// flag word bit positions
`define CXM_PSW_CY    0
`define CXM_PSW_OV    1
`define CXM_PSW_BANK  3

// direct byte space above the 32-byte internal ram
`define CXM_DIR_P1    6'h20
`define CXM_DIR_P2    6'h21
`define CXM_DIR_ACC   6'h22
`define CXM_DIR_B     6'h23

// reset values
`define CXM_RST_PORT  8'hff
`define CXM_RST_BYTE  8'h00
`define CXM_RST_WORD  16'h0000

`endif

// [verilog/cxm_pkg.sv]
// types shared by the execution unit
`default_nettype none
package cxm_pkg;

	// operation selected by a command write
	typedef enum logic [4:0] {
		CXM_OP_IDLE       = 5'h00,
		CXM_OP_MOVC_DP    = 5'h01,
		CXM_OP_MOVC_PC    = 5'h02,
		CXM_OP_MOVX_RD_RI = 5'h03,
		CXM_OP_MOVX_WR_RI = 5'h04,
		CXM_OP_MOVX_RD_DP = 5'h05,
		CXM_OP_MOVX_WR_DP = 5'h06,
		CXM_OP_MUL        = 5'h07,
		CXM_OP_ORL_A_REG  = 5'h08,
		CXM_OP_ORL_A_DIR  = 5'h09,
		CXM_OP_ORL_A_IND  = 5'h0a,
		CXM_OP_ORL_A_IMM  = 5'h0b,
		CXM_OP_ORL_DIR_A  = 5'h0c,
		CXM_OP_ORL_DIR_IM = 5'h0d,
		CXM_OP_ORL_C_BIT  = 5'h0e,
		CXM_OP_ORL_C_NBIT = 5'h0f
	} cxm_op_t;

	// command word layout
	typedef struct packed {
		logic [7:0] imm;
		logic [4:0] rsv1;
		logic [2:0] bitsel;
		logic [1:0] rsv0;
		logic [5:0] dir;
		logic [2:0] rsel;
		cxm_op_t    op;
	} cxm_cmd_t;

	// sequencer states
	typedef enum logic [2:0] {
		CXM_ST_WAIT = 3'b001,
		CXM_ST_RUN  = 3'b010,
		CXM_ST_DONE = 3'b100
	} cxm_state_t;

	// multiplexed external data bus
	typedef struct packed {
		logic       ale;
		logic       rd_n;
		logic       wr_n;
		logic       p0_oe;
		logic [7:0] p0;
		logic [7:0] p2;
	} cxm_xbus_t;

endpackage
`default_nettype wire

// [dv/cxm_xram_model.sv]
// external data ram and code memory model facing the execution unit
`timescale 1ns/1ps
`default_nettype none
module cxm_xram_model (
	// clock, reset and answer pace
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               slow_i,
	// multiplexed external bus
	input  wire cxm_pkg::cxm_xbus_t xbus_i,
	output logic [7:0]              p0_o,
	// code memory port
	input  wire logic [15:0]        code_addr_i,
	input  wire logic               code_req_i,
	output logic [7:0]              code_data_o,
	output logic                    code_ack_o
);
	import cxm_pkg::*;
	logic [7:0]  mem [0:65535];
	logic [15:0] addr_q;
	logic [5:0]  wait_q;
	////////////////////////////////////////////////////////////
	// address caught while ale is high, write byte while strobe low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p0_o <= 8'h00;
		end else begin
			if (xbus_i.ale) begin
				addr_q <= {xbus_i.p2, xbus_i.p0};
			end
			if (!xbus_i.wr_n) begin
				mem[addr_q] <= xbus_i.p0;
			end
			// a released bus toggles, so a stale byte never passes for data
			p0_o <= !xbus_i.rd_n ? mem[addr_q] : ~p0_o;
		end
	end
	////////////////////////////////////////////////////////////
	// code answer after two cycles, or after 31 when slow (longer than the run phase)
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i || !code_req_i) begin
			wait_q <= 6'h00;
			code_ack_o <= 1'b0;
		end else begin
			wait_q <= wait_q + 6'h01;
			code_ack_o <= wait_q >= (slow_i ? 6'h1e : 6'h01);
		end
	end
	assign code_data_o = code_ack_o ? code_addr_i[7:0] ^ code_addr_i[15:8] ^ 8'h5c : ~code_addr_i[7:0];
endmodule
`default_nettype wire

// [dv/tb_code_xdata_mul_or_exec.sv]
// self-checking bench for the execution unit with its external ram model
`timescale 1ns/1ps
`default_nettype none
module tb_code_xdata_mul_or_exec;
	import cxm_pkg::*;
	logic        clk, rst_n, psel, pen, pwr, slow, sl, pready, pslverr, creq, cack;
	logic [7:0]  paddr, p1_pin, p0_pin, cdata, p1;
	logic [15:0] caddr;
	logic [31:0] pwdata, prdata, q;
	cxm_xbus_t   xbus;
	int          error_cnt, tests_run, cyc;
	cxm_exec DUT (.CLK_SYS_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.CODE_ADDR_O(caddr), .CODE_REQ_O(creq), .CODE_DATA_I(cdata), .CODE_ACK_I(cack), .XBUS_O(xbus),
		.P0_PIN_I(p0_pin), .P1_PIN_I(p1_pin), .P1_O(p1));
	cxm_xram_model xm (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .xbus_i(xbus), .p0_o(p0_pin),
		.code_addr_i(caddr), .code_req_i(creq), .code_data_o(cdata), .code_ack_o(cack));
	////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		sl = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		check(n, q, e);
	endtask
	// wait for busy to clear, bounded so a hang still ends
	task automatic idle_wait();
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 300);
	endtask
	task automatic op(input logic [4:0] o, input logic [2:0] r, input logic [5:0] d, input logic [2:0] b,
		input logic [7:0] i);
		apb(1'b1, 8'h00, {i, 5'h00, b, 2'h0, d, r, o});
		idle_wait();
	endtask
	function automatic logic [31:0] cb(input logic [15:0] a);
		return {24'h0, a[7:0] ^ a[15:8] ^ 8'h5c};
	endfunction
	////////////////////////////////////////////////////////////
	task automatic t_movc();
		apb(1'b1, 8'h10, 32'h12f0);
		apb(1'b1, 8'h08, 32'h20);
		apb(1'b1, 8'h18, 32'h3);
		op(5'h01, 3'h0, 6'h0, 3'h0, 8'h0);
		rd(8'h08, cb(16'h1310), "movc dptr");
		rd(8'h10, 32'h12f0, "dptr kept");
		rd(8'h18, 32'h3, "movc flags");
		slow <= 1'b1;
		apb(1'b1, 8'h14, 32'h00ff);
		apb(1'b1, 8'h08, 32'h05);
		op(5'h02, 3'h0, 6'h0, 3'h0, 8'h0);
		rd(8'h08, cb(16'h0105), "movc pc");
		rd(8'h14, 32'h0100, "pc advanced");
		slow <= 1'b0;
	endtask
	task automatic t_movx();
		apb(1'b1, 8'h1c, 32'h5a00);
		apb(1'b1, 8'h10, 32'hab34);
		apb(1'b1, 8'h08, 32'h77);
		op(5'h06, 3'h0, 6'h0, 3'h0, 8'h0);
		check("xram long", {24'h0, xm.mem[16'hab34]}, 32'h77);
		apb(1'b1, 8'h08, 32'h0);
		op(5'h05, 3'h0, 6'h0, 3'h0, 8'h0);
		rd(8'h08, 32'h77, "movx rd long");
		rd(8'h1c, 32'h5a00, "p2 latch kept");
		apb(1'b1, 8'h1c, 32'h3cff);
		apb(1'b1, 8'h84, 32'h12);
		apb(1'b1, 8'h08, 32'h99);
		op(5'h04, 3'h1, 6'h0, 3'h0, 8'h0);
		check("xram short", {24'h0, xm.mem[16'h3c12]}, 32'h99);
		apb(1'b1, 8'h80, 32'h12);
		apb(1'b1, 8'h08, 32'h0);
		op(5'h03, 3'h0, 6'h0, 3'h0, 8'h0);
		rd(8'h08, 32'h99, "movx rd short");
	endtask
	task automatic t_mul();
		logic [7:0]  a [3] = '{8'h50, 8'h0f, 8'hff};
		logic [7:0]  b [3] = '{8'ha0, 8'h11, 8'hff};
		logic [15:0] p;
		for (int k = 0; k < 3; k++) begin
			p = a[k] * b[k];
			apb(1'b1, 8'h08, {24'h0, a[k]});
			apb(1'b1, 8'h0c, {24'h0, b[k]});
			apb(1'b1, 8'h18, {30'h0, p <= 16'h00ff, 1'b1});
			apb(1'b1, 8'h00, 32'h07);
			rd(8'h08, {24'h0, a[k]}, "mul midway");
			// a write while busy is refused and leaves the pointer alone
			apb(1'b1, 8'h10, 32'h00aa);
			check("busy refused", {31'h0, sl}, 32'h1);
			idle_wait();
			rd(8'h08, {24'h0, p[7:0]}, "mul low");
			rd(8'h0c, {24'h0, p[15:8]}, "mul high");
			rd(8'h18, {30'h0, p > 16'h00ff, 1'b0}, "mul flags");
			rd(8'h10, 32'hab34, "busy write void");
		end
	endtask
	task automatic t_idle();
		apb(1'b1, 8'h14, 32'hffff);
		apb(1'b1, 8'h08, 32'h5e);
		apb(1'b1, 8'h18, 32'h3);
		op(5'h00, 3'h0, 6'h0, 3'h0, 8'h0);
		rd(8'h14, 32'h0, "idle pc");
		rd(8'h08, 32'h5e, "idle acc");
		rd(8'h18, 32'h3, "idle flags");
		rd(8'h20, 32'h0, "unmapped data");
		check("unmapped error", {31'h0, sl}, 32'h1);
	endtask
	task automatic t_orl();
		apb(1'b1, 8'h80, 32'h04);
		apb(1'b1, 8'h90, 32'h55);
		apb(1'b1, 8'h18, 32'h3);
		// register, direct and indirect sources all reach byte 4; the immediate carries the same value
		for (int k = 8; k < 12; k++) begin
			apb(1'b1, 8'h08, 32'hc3);
			op(k[4:0], 3'h4, 6'h04, 3'h0, 8'h55);
			rd(8'h08, 32'hd7, "orl acc");
		end
		op(5'h0c, 3'h0, 6'h04, 3'h0, 8'h0);
		rd(8'h90, 32'hd7, "orl dir acc");
		op(5'h0d, 3'h0, 6'h04, 3'h0, 8'h28);
		rd(8'h90, 32'hff, "orl dir imm");
		rd(8'h18, 32'h3, "orl flags");
		apb(1'b1, 8'h1c, 32'h3c01);
		p1_pin <= 8'h80;
		op(5'h0d, 3'h0, 6'h20, 3'h0, 8'h30);
		check("port latch", {24'h0, p1}, 32'h31);
		// as a plain source the port is read from its synchronised pins
		apb(1'b1, 8'h08, 32'h01);
		op(5'h09, 3'h0, 6'h20, 3'h0, 8'h0);
		rd(8'h08, 32'h81, "orl pins src");
		apb(1'b1, 8'h18, 32'h0);
		apb(1'b1, 8'h08, 32'h80);
		op(5'h0e, 3'h0, 6'h22, 3'h7, 8'h0);
		rd(8'h18, 32'h1, "bit one");
		op(5'h0e, 3'h0, 6'h22, 3'h0, 8'h0);
		rd(8'h18, 32'h1, "bit zero");
		apb(1'b1, 8'h18, 32'h0);
		op(5'h0f, 3'h0, 6'h22, 3'h7, 8'h0);
		rd(8'h18, 32'h0, "nbit one");
		rd(8'h08, 32'h80, "source kept");
		op(5'h0f, 3'h0, 6'h22, 3'h0, 8'h0);
		rd(8'h18, 32'h1, "nbit zero");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// a hang counts as a mismatch and still ends in the report
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		{rst_n, psel, pen, pwr, slow, paddr, pwdata, p1_pin} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_movc();
		t_movx();
		t_mul();
		t_idle();
		t_orl();
		final_report();
	end
endmodule
`default_nettype wire
